/* File: shared/ssgc_regs.svh */
`ifndef SSGC_REGS_SVH
`define SSGC_REGS_SVH
// ****************************************
// Register indices; the bus byte address is four times the index
// ****************************************
`define SSGC_IDX_FLAGS 6'h00
`define SSGC_IDX_CTRL 6'h01
`define SSGC_IDX_IRQ_STAT 6'h02
`define SSGC_IDX_IRQ_MASK 6'h03
`define SSGC_IDX_OPMODE 6'h04
// ****************************************
// Field positions
// ****************************************
`define SSGC_FL_BROWNOUT 0
`define SSGC_FL_INCRC 1
`define SSGC_FL_CFGCRC 2
`define SSGC_FL_AVG 3
`define SSGC_FL_SEQ 6
`define SSGC_FL_ONE 7
`define SSGC_CT_CRC 6
`define SSGC_CT_STATS 5
`define SSGC_CT_WIN 4
`define SSGC_CT_FORCE 2
`define SSGC_CT_CAL 1
`define SSGC_CT_SRST 0
`define SSGC_OP_HALT 0
// ****************************************
// Reset values and masks
// ****************************************
`define SSGC_FLAGS_RST 8'h81
`define SSGC_CTRL_RST 8'h00
`define SSGC_CTRL_RW_MASK 8'h76
`define SSGC_IRQ_EV_MASK 8'h0b
`define SSGC_SRST_CYCLES 4'h4
`endif

/* File: shared/ssgc_pkg.sv */
package ssgc_pkg;
   typedef enum logic [2:0] {
      SSGC_RUN = 3'b001,
      SSGC_SRST = 3'b010,
      SSGC_CAL = 3'b100
   } ssgc_state_t;

   // Control outputs travelling together to the converter core
   typedef struct packed {
      logic crc_enable;
      logic stats_clear;
      logic stats_update;
      logic window_enable;
      logic force_analog;
      logic seq_pause;
      logic cal_start;
      logic soft_reset;
   } ssgc_ctrl_t;

   typedef struct packed {
      ssgc_state_t st;
      logic [7:0] flags;
      logic [7:0] ctrl;
      logic [7:0] irq_stat;
      logic [7:0] irq_mask;
      logic halt_on_link_error;
      logic [3:0] cnt;
      logic ack;
      logic [31:0] dat;
      logic irq;
      ssgc_ctrl_t core;
   } ssgc_st_t;
endpackage

/* File: hdl/ssgc_top.sv */
// The Wishbone register port is this design's own decision.
`timescale 1ns/100ps
`include "ssgc_regs.svh"
// Operation
// - Sequencer flag mirrors sequence running; read-only
// - Average ready set on completion; W1C
// - Config CRC fault read-only; rechecked at reset (here only a soft reset samples it; power-up leaves it clear)
// - Inbound CRC fault set on mismatch; W1C
// - While CRC fault, only addresses 0,1 writable
// - Brownout flag resets one; W1C; set on brownout
// - CRC enable bit 6 drives link CRC
// - Stats enable bit 5 clears then updates
// - Window enable bit 4; zero holds comparator reset
// - Force bit 2 makes all channels analog
// - Calibrate bit 1 self-clears when done
// - Soft reset restores defaults, sets brownout
// - General control resets to all zeros
// - Flags at address zero reset to 0x81
// - Halt on link error forces analog, pauses
module ssgc_top
   import ssgc_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o,
   input wire logic seq_running_i,
   input wire logic avg_done_i,
   input wire logic cfg_crc_bad_i,
   input wire logic link_crc_err_i,
   input wire logic brownout_i,
   input wire logic cal_done_i,
   output ssgc_ctrl_t core_o
);
   ssgc_st_t r;
   ssgc_st_t next_r;
   // Decoded request
   logic req;
   logic wr;
   logic rd_req;
   logic wr_open;
   logic [5:0] idx;
   logic [7:0] wbyte;
   // Event bits in flag layout
   logic [7:0] events;
   ssgc_ctrl_t core_lv;

   // ****************************************
   // Helper functions
   // ****************************************

   // Register index compare; the bus carries byte addresses, the bank counts words
   function automatic logic hit(input logic [5:0] a, input logic [5:0] b);
      return a == b;
   endfunction

   // Write-one-to-clear merge; bits written as zero keep their value
   function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] wdata, input logic [7:0] mask);
      return cur & ~(wdata & mask);
   endfunction

   // Flags and control stay writable during a CRC fault so the host can recover
   function automatic logic writable(input logic [5:0] a, input logic fault);
      return hit(a, `SSGC_IDX_FLAGS) || hit(a, `SSGC_IDX_CTRL) || !fault;
   endfunction

   // Halt-on-error condition, shared by the analog override and the pause
   function automatic logic halted(input logic halt_en, input logic fault);
      return halt_en && fault;
   endfunction

   // Control write merge; reserved bits drop and a running calibration stays armed
   function automatic logic [7:0] ctrl_write(input logic [7:0] cur, input logic [7:0] wdata);
      logic [7:0] v;
      v = wdata & `SSGC_CTRL_RW_MASK;
      // A zero written during calibration must not abort it
      if (cur[`SSGC_CT_CAL]) begin
         v[`SSGC_CT_CAL] = 1'b1;
      end
      return v;
   endfunction

   // Core control word from the stored control bits and the halt condition
   function automatic ssgc_ctrl_t core_from(input logic [7:0] ctl, input logic halt_en, input logic fault);
      ssgc_ctrl_t c;
      c = '0;
      c.crc_enable = ctl[`SSGC_CT_CRC];
      c.stats_update = ctl[`SSGC_CT_STATS];
      c.window_enable = ctl[`SSGC_CT_WIN];
      // Halt overrides the pin setup until the host clears the fault
      c.force_analog = ctl[`SSGC_CT_FORCE] || halted(halt_en, fault);
      c.seq_pause = halted(halt_en, fault);
      return c;
   endfunction

   // Read multiplexer; unmapped words read as zero so probing is harmless
   function automatic logic [7:0] rd_mux(input logic [5:0] a, input ssgc_st_t s);
      logic [7:0] v;
      v = 8'h00;
      // Reserved flag bits are never set, so they read zero
      case (a)
         `SSGC_IDX_FLAGS: begin
            v = s.flags;
         end
         `SSGC_IDX_CTRL: begin
            v = s.ctrl; // Soft reset bit is never stored, so it reads zero
         end
         `SSGC_IDX_IRQ_STAT: begin
            v = s.irq_stat;
         end
         `SSGC_IDX_IRQ_MASK: begin
            v = s.irq_mask;
         end
         `SSGC_IDX_OPMODE: begin
            v = {7'h00, s.halt_on_link_error};
         end
         default: begin
            v = 8'h00;
         end
      endcase
      return v;
   endfunction

   // ****************************************
   // Bus decode
   // ****************************************

   // Classic single cycle: a request is taken at the first edge that sees
   // cyc and stb high with ack low; ack and read data follow one cycle later
   // and stand for that cycle only. The strobe still held in the ack cycle is
   // not taken again, so every access costs two edges plus the host's gap.
   assign req = wb_cyc_i && wb_stb_i && !r.ack;
   assign idx = wb_adr_i[7:2];
   // Only byte lane 0 carries register data
   assign wbyte = wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00;
   assign wr = req && wb_we_i && wb_sel_i[0];
   assign rd_req = req && !wb_we_i;
   // Lock is judged on the stored fault, not on a same-cycle event
   assign wr_open = writable(idx, r.flags[`SSGC_FL_INCRC]);

   // ****************************************
   // Next-state logic
   // ****************************************

   // All register updates in one place; the order below sets priority
   always_comb begin
      next_r = r;
      events = 8'h00;
      core_lv = '0;
      // Strobes last one cycle unless re-armed below
      next_r.ack = req;
      next_r.core.cal_start = 1'b0;
      next_r.core.stats_clear = 1'b0;
      next_r.core.soft_reset = 1'b0;

      // Live status, sampled every cycle
      next_r.flags[`SSGC_FL_SEQ] = seq_running_i;
      next_r.flags[`SSGC_FL_ONE] = 1'b1;

      // ****************************************
      // Event capture
      // ****************************************
      // Collected first, merged after the bus write so a set wins
      if (avg_done_i) begin
         events[`SSGC_FL_AVG] = 1'b1;
      end
      // Link errors count only while the link CRC is switched on
      if (link_crc_err_i && r.ctrl[`SSGC_CT_CRC]) begin
         events[`SSGC_FL_INCRC] = 1'b1;
      end
      if (brownout_i) begin
         events[`SSGC_FL_BROWNOUT] = 1'b1;
      end

      // ****************************************
      // Register writes
      // ****************************************
      if (wr && wr_open) begin
         if (hit(idx, `SSGC_IDX_FLAGS)) begin
            // Only event flags clear; the fixed one, sequencer and config fault ignore writes
            next_r.flags = w1c(next_r.flags, wbyte, `SSGC_IRQ_EV_MASK);
         end else if (hit(idx, `SSGC_IDX_CTRL)) begin
            next_r.ctrl = ctrl_write(r.ctrl, wbyte);
            // A new calibration starts only from idle, so a rewrite cannot restart it
            if (wbyte[`SSGC_CT_CAL] && !r.ctrl[`SSGC_CT_CAL]) begin
               next_r.core.cal_start = 1'b1;
            end
            // Statistics are cleared on the enabling edge only
            if (wbyte[`SSGC_CT_STATS] && !r.ctrl[`SSGC_CT_STATS]) begin
               next_r.core.stats_clear = 1'b1;
            end
            // Soft reset bit is write-only; it starts the reset sequence
            if (wbyte[`SSGC_CT_SRST]) begin
               next_r.st = SSGC_SRST;
               next_r.cnt = `SSGC_SRST_CYCLES;
            end
         end else if (hit(idx, `SSGC_IDX_IRQ_STAT)) begin
            next_r.irq_stat = w1c(r.irq_stat, wbyte, `SSGC_IRQ_EV_MASK);
         end else if (hit(idx, `SSGC_IDX_IRQ_MASK)) begin
            next_r.irq_mask = wbyte & `SSGC_IRQ_EV_MASK;
         end else if (hit(idx, `SSGC_IDX_OPMODE)) begin
            next_r.halt_on_link_error = wbyte[`SSGC_OP_HALT];
         end
      end

      // Merge events after the write so a same-cycle clear loses to a new event
      next_r.flags = next_r.flags | events;
      next_r.irq_stat = next_r.irq_stat | events;

      // ****************************************
      // Soft reset and calibration sequencer
      // ****************************************
      case (r.st)
         SSGC_RUN: begin
            // Calibration bit falls when the converter reports completion
            if (r.ctrl[`SSGC_CT_CAL] && cal_done_i) begin
               next_r.ctrl[`SSGC_CT_CAL] = 1'b0;
            end
         end
         SSGC_SRST: begin
            // Core sees a reset level for the whole count
            next_r.core.soft_reset = 1'b1;
            next_r.cnt = r.cnt - 4'h1;
            if (r.cnt == 4'h1) begin
               // Defaults restored; config CRC reevaluated here
               next_r.st = SSGC_RUN;
               next_r.ctrl = `SSGC_CTRL_RST;
               next_r.irq_stat = 8'h00;
               next_r.irq_mask = 8'h00;
               next_r.halt_on_link_error = 1'b0;
               // Brownout reads set again after the reset, as after power-up
               next_r.flags = `SSGC_FLAGS_RST;
               next_r.flags[`SSGC_FL_CFGCRC] = cfg_crc_bad_i;
            end
         end
         SSGC_CAL: begin
            // Not entered; calibration runs alongside normal access
            next_r.st = SSGC_RUN;
         end
         default: begin
            next_r.st = SSGC_RUN;
         end
      endcase

      // ****************************************
      // Read data
      // ****************************************
      // Data stands only in the ack cycle and is zero otherwise
      next_r.dat = 32'h0000_0000;
      if (rd_req) begin
         next_r.dat[7:0] = rd_mux(idx, r);
      end

      // ****************************************
      // Core controls
      // ****************************************
      // Levels follow the next state so the core sees them with the register
      core_lv = core_from(next_r.ctrl, next_r.halt_on_link_error, next_r.flags[`SSGC_FL_INCRC]);
      next_r.core.crc_enable = core_lv.crc_enable;
      next_r.core.stats_update = core_lv.stats_update;
      next_r.core.window_enable = core_lv.window_enable;
      next_r.core.force_analog = core_lv.force_analog;
      next_r.core.seq_pause = core_lv.seq_pause;
      // Level interrupt; follows the next status so it never lags a clear
      next_r.irq = |(next_r.irq_stat & next_r.irq_mask);
   end

   // ****************************************
   // State register
   // ****************************************

   // Power-up leaves the config CRC fault clear; only a soft reset samples the
   // checker input, because the asynchronous branch may hold constants only.
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         r <= '{st: SSGC_RUN, flags: `SSGC_FLAGS_RST, ctrl: `SSGC_CTRL_RST, default: '0};
      end else begin
         r <= next_r;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************

   // Every output is a field of the state register
   assign wb_dat_o = r.dat;
   assign wb_ack_o = r.ack;
   assign irq_o = r.irq;
   assign core_o = r.core;
endmodule // ssgc_top

/* File: tb/ssgc_top_chk.sv */
`timescale 1ns/100ps
// ****
// Bus and control checker
// ****
module ssgc_chk
   import ssgc_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire ssgc_ctrl_t core_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   // Reads are judged at the ack edge, while the host still holds the request
   wire rd = wb_ack_o && !wb_we_i;
   ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
   ack_late_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
   dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
   flag_one_a: assert property (rd && wb_adr_i == 8'h00 |-> wb_dat_o[7]) else $error("fixed one lost");
   ctrl_rsv_a: assert property (rd && wb_adr_i == 8'h04 |-> wb_dat_o[31:7] == 0 && !wb_dat_o[3] && !wb_dat_o[0])
      else $error("control reads wrong");
   unmap_zero_a: assert property (rd && wb_adr_i[7:2] > 6'h04 |-> wb_dat_o == 32'h0) else $error("unmapped data");
   srst_len_a: assert property ($rose(core_o.soft_reset) |-> core_o.soft_reset[*4] ##1 !core_o.soft_reset)
      else $error("soft reset length");
   cal_pulse_a: assert property (core_o.cal_start |=> !core_o.cal_start) else $error("cal start not a pulse");
   clr_pulse_a: assert property (core_o.stats_clear |=> !core_o.stats_clear) else $error("clear not a pulse");
   crc_win_a: assert property (rd && wb_adr_i == 8'h04 |-> wb_dat_o[6] == core_o.crc_enable)
      else $error("crc enable differs");
   win_out_a: assert property (rd && wb_adr_i == 8'h04 |-> wb_dat_o[4] == core_o.window_enable)
      else $error("window enable differs");
   srst_ctrl_a: assert property ($fell(core_o.soft_reset) |-> !core_o.window_enable && !core_o.stats_update)
      else $error("controls kept over soft reset");
   halt_force_a: assert property (core_o.seq_pause |-> core_o.force_analog)
      else $error("pause without analog override");
endmodule // ssgc_chk
bind ssgc_top ssgc_chk u_chk (.sys_clk_i, .resetn_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
   .wb_ack_o, .core_o);

/* File: tb/ssgc_host.sv */
`timescale 1ns/100ps
// ****
// Wishbone host model
// ****
module ssgc_host (
   input wire logic sys_clk_i,
   input wire logic wb_ack_i,
   input wire logic [31:0] wb_dat_i,
   output logic wb_cyc_o,
   output logic wb_stb_o,
   output logic wb_we_o,
   output logic [7:0] wb_adr_o,
   output logic [3:0] wb_sel_o,
   output logic [31:0] wb_dat_o
);
   initial {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} = '0;
   // One classic cycle; released data shows its inverse so stale bytes never look valid
   task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
      output logic ok);
      int n;
      n = 0;
      @(posedge sys_clk_i);
      {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} <= {2'b11, we, a, 4'hf, d};
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (wb_ack_i !== 1'b1 && n < 64);
      q = wb_dat_i;
      ok = (wb_ack_i === 1'b1);
      {wb_cyc_o, wb_stb_o, wb_dat_o} <= {2'b00, ~d};
      @(posedge sys_clk_i);
   endtask
endmodule // ssgc_host

/* File: tb/system_status_general_control_tb.sv */
`timescale 1ns/100ps
// ****
// Register bank bench
// ****
module system_status_general_control_tb;
   import ssgc_pkg::*;
   logic sys_clk = 1'b0;
   logic resetn, seq_run, cfg_bad, cyc, stb, we, ack, irq;
   logic [3:0] evt, sel;
   logic [7:0] adr;
   logic [31:0] wdat, rdat, q;
   ssgc_ctrl_t core;
   int mismatches = 0;
   int compares = 0;
   int fl, ct;
   always #10 sys_clk = ~sys_clk;
   ssgc_top u_dut (.sys_clk_i(sys_clk), .resetn_i(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq),
      .seq_running_i(seq_run), .avg_done_i(evt[0]), .cfg_crc_bad_i(cfg_bad), .link_crc_err_i(evt[1]),
      .brownout_i(evt[2]), .cal_done_i(evt[3]), .core_o(core));
   ssgc_host u_host (.sys_clk_i(sys_clk), .wb_ack_i(ack), .wb_dat_i(rdat), .wb_cyc_o(cyc), .wb_stb_o(stb),
      .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat));
   // Comparison, verdict and bus helpers
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic acc(input logic w, input logic [7:0] a, input int d);
      logic ok;
      u_host.xfer(w, a, d, q, ok);
      if (!ok) begin
         mismatches++;
         tally_and_finish();
      end
   endtask
   task automatic rd(input logic [7:0] a, input int e, input string n);
      acc(1'b0, a, 0);
      chk(n, q, e);
   endtask
   task automatic pulse(input logic [3:0] m);
      evt <= m;
      @(posedge sys_clk);
      evt <= 4'h0;
   endtask
   // Main sequence; the ints fl and ct model the two registers
   initial begin
      {resetn, seq_run, cfg_bad, evt} = '0;
      void'($urandom(90173));
      repeat (10) @(posedge sys_clk);
      resetn <= 1'b1;
      fl = 'h81;
      ct = 0;
      rd(8'h00, fl, "flags");
      rd(8'h04, ct, "ctrl");
      rd(8'h40, 0, "unmapped");
      repeat (4) begin
         ct = $urandom & 'h74;
         acc(1'b1, 8'h04, ct);
         rd(8'h04, ct, "ctrl rw");
         chk("crc en", core.crc_enable, ct[6]);
         chk("statistics_enable", core.stats_update, ct[5]);
         chk("window en", core.window_enable, ct[4]);
         chk("force", core.force_analog, ct[2]);
      end
      acc(1'b1, 8'h00, 0);
      rd(8'h00, fl, "flags w0");
      seq_run <= 1'b1;
      pulse(4'h1);
      rd(8'h00, 'hc9, "flags set");
      acc(1'b1, 8'h00, 'h49);
      rd(8'h00, 'hc0, "flags w1c");
      seq_run <= 1'b0;
      acc(1'b1, 8'h04, 'h40);
      pulse(4'h2);
      rd(8'h00, 'h82, "crc fault");
      acc(1'b1, 8'h0c, 'h02);
      rd(8'h0c, 0, "mask locked");
      acc(1'b1, 8'h00, 'h02);
      acc(1'b1, 8'h0c, 'h02);
      chk("irq set", irq, 1);
      acc(1'b1, 8'h08, 'h02);
      chk("irq clr", irq, 0);
      // Halt on link error: fault forces analog and pauses until cleared
      acc(1'b1, 8'h10, 'h01);
      rd(8'h10, 1, "opmode");
      pulse(4'h2);
      @(posedge sys_clk);
      chk("halt force", core.force_analog, 1);
      chk("halt pause", core.seq_pause, 1);
      acc(1'b1, 8'h00, 'h02);
      chk("resume force", core.force_analog, 0);
      chk("resume pause", core.seq_pause, 0);
      acc(1'b1, 8'h04, 'h02);
      rd(8'h04, 'h02, "cal");
      pulse(4'h8);
      rd(8'h04, 0, "cal done");
      cfg_bad <= 1'b1;
      acc(1'b1, 8'h04, 'h31);
      repeat (8) @(posedge sys_clk);
      acc(1'b1, 8'h00, 'h04);
      rd(8'h00, 'h85, "flags srst");
      rd(8'h04, 0, "ctrl srst");
      rd(8'h10, 0, "opmode srst");
      tally_and_finish();
   end
endmodule // system_status_general_control_tb
